// ===== field_trigger_pulse_gen.v
/*
 * Field trigger pulse generator of the timing core. Holds the pulse
 * registers written over the serial port, counts mode fields, places the
 * pulse inside the selected field and drives it on the shared align pin.
 * Assumes the mode sequencer supplies the number of fields in its sequence
 * and that drive strobes and serial pins are synchronous to mclk.
 */
`timescale 1ns/1ps
`include "field_trigger_consts.vh"

module field_trigger_pulse_gen #(
	parameter LINE_W  = 12,
	parameter PIX_W   = 13,
	parameter FIELD_W = 3
) (
	// clock and reset
	input  wire               mclk_in,
	input  wire               rst_n_in,
	// serial register port
	input  wire               sclk_in,
	input  wire               sdata_in,
	input  wire               sload_n_in,
	// drive strobes
	input  wire               vertical_drive_strobe_in,
	input  wire               horizontal_drive_strobe_in,
	// mode sequencer
	input  wire [FIELD_W-1:0] mode_field_total_in,
	// align pin
	input  wire               align_pin_in,
	output reg                align_pin_out,
	output reg                align_pin_oe_out,
	// to timing core
	output reg                ext_sync_out,
	output reg                field_trigger_pulse_out,
	output reg  [FIELD_W-1:0] field_count_out
);

	// serial write strobe
	wire                   wr;
	wire [`SER_ADDR_W-1:0] wr_addr;
	wire [`SER_DATA_W-1:0] wr_data;

	// drive strobe edges
	reg  vd_q;
	reg  hd_q;
	wire vd_fall;
	wire hd_fall;

	// position
	wire [LINE_W-1:0] line_pos;
	wire [PIX_W-1:0]  pixel_pos;

	// written copies
	reg               pin_dir_q;
	reg               start_pol_q;
	reg  [3:0]        ctrl_q;
	reg  [LINE_W-1:0] on_line_q;
	reg  [PIX_W-1:0]  on_pix_q;
	reg  [LINE_W-1:0] off_line_q;
	reg  [PIX_W-1:0]  off_pix_q;

	// active copies
	reg               act_dir_q;
	reg               act_pol_q;
	reg  [3:0]        act_ctrl_q;
	reg  [LINE_W-1:0] act_on_line_q;
	reg  [PIX_W-1:0]  act_on_pix_q;
	reg  [LINE_W-1:0] act_off_line_q;
	reg  [PIX_W-1:0]  act_off_pix_q;
	reg               update_pend_q;
	wire              update_now;

	// pulse state
	reg                level_q;
	reg                level_d;
	reg  [FIELD_W-1:0] field_q;
	reg  [FIELD_W-1:0] field_d;
	wire               in_field;
	wire               hit_on;
	wire               hit_off;
	wire               pulse_en;

	serial_write_port u_serial (
		.mclk_in     (mclk_in),
		.rst_n_in    (rst_n_in),
		.sclk_in     (sclk_in),
		.sdata_in    (sdata_in),
		.sload_n_in  (sload_n_in),
		.wr_out      (wr),
		.wr_addr_out (wr_addr),
		.wr_data_out (wr_data)
	);

	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			vd_q <= 1'b1;
			hd_q <= 1'b1;
		end else begin
			vd_q <= vertical_drive_strobe_in;
			hd_q <= horizontal_drive_strobe_in;
		end
	end

	assign vd_fall = vd_q & ~vertical_drive_strobe_in;
	assign hd_fall = hd_q & ~horizontal_drive_strobe_in;

	drive_position_counter #(
		.LINE_W (LINE_W),
		.PIX_W  (PIX_W)
	) u_pos (
		.mclk_in    (mclk_in),
		.rst_n_in   (rst_n_in),
		.vd_fall_in (vd_fall),
		.hd_fall_in (hd_fall),
		.line_out   (line_pos),
		.pixel_out  (pixel_pos)
	);

	// serial-side register file; unmapped addresses are ignored
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin_dir_q   <= `RST_PIN_DIR;
			start_pol_q <= `RST_START_POL;
			ctrl_q      <= `RST_CTRL;
			on_line_q   <= `RST_LINE;
			on_pix_q    <= `RST_PIX;
			off_line_q  <= `RST_LINE;
			off_pix_q   <= `RST_PIX;
		end else if (wr) begin
			if (wr_addr == `ADDR_PIN_DIR) begin
				pin_dir_q <= wr_data[`DIR_BIT];
			end else if (wr_addr == `ADDR_START_POL) begin
				start_pol_q <= wr_data[`POL_BIT];
			end else if (wr_addr == `ADDR_ON_POS) begin
				on_line_q <= wr_data[`POS_LINE_HI:`POS_LINE_LO];
				on_pix_q  <= wr_data[`POS_PIX_HI:`POS_PIX_LO];
			end else if (wr_addr == `ADDR_OFF_POS) begin
				off_line_q <= wr_data[`POS_LINE_HI:`POS_LINE_LO];
				off_pix_q  <= wr_data[`POS_PIX_HI:`POS_PIX_LO];
			end else if (wr_addr == `ADDR_PULSE_CTRL) begin
				ctrl_q <= wr_data[3:0];
			end
		end
	end

	assign update_now = hd_fall & (update_pend_q | vd_fall);

	// written values go live at the first hd fall at or after a vd fall
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			update_pend_q  <= 1'b0;
			act_dir_q      <= `RST_PIN_DIR;
			act_pol_q      <= `RST_START_POL;
			act_ctrl_q     <= `RST_CTRL;
			act_on_line_q  <= `RST_LINE;
			act_on_pix_q   <= `RST_PIX;
			act_off_line_q <= `RST_LINE;
			act_off_pix_q  <= `RST_PIX;
		end else begin
			if (update_now) begin
				update_pend_q  <= 1'b0;
				act_dir_q      <= pin_dir_q;
				act_pol_q      <= start_pol_q;
				act_ctrl_q     <= ctrl_q;
				act_on_line_q  <= on_line_q;
				act_on_pix_q   <= on_pix_q;
				act_off_line_q <= off_line_q;
				act_off_pix_q  <= off_pix_q;
			end else if (vd_fall) begin
				update_pend_q <= 1'b1;
			end
		end
	end

	// field count follows the mode sequence, not shutter field settings
	always @* begin
		field_d = field_q;
		if (vd_fall) begin
			// one extra bit so the top count cannot wrap before the compare
			if ({1'b0, field_q} + {{FIELD_W{1'b0}}, 1'b1} >= {1'b0, mode_field_total_in})
				field_d = {FIELD_W{1'b0}};
			else
				field_d = field_q + {{(FIELD_W-1){1'b0}}, 1'b1};
		end
	end

	assign pulse_en = act_ctrl_q[`CTRL_EN_BIT];
	assign in_field = (field_q == act_ctrl_q[`CTRL_SEL_HI:`CTRL_SEL_LO]);
	assign hit_on   = (line_pos == act_on_line_q) && (pixel_pos == act_on_pix_q);
	assign hit_off  = (line_pos == act_off_line_q) && (pixel_pos == act_off_pix_q);

	always @* begin
		level_d = level_q;
		if (update_now) begin
			// new polarity goes live here, so start the field at its level
			level_d = start_pol_q;
		end else if (vd_fall || !pulse_en || !in_field) begin
			level_d = act_pol_q;
		end else if (hit_off) begin
			level_d = act_pol_q;
		end else if (hit_on) begin
			level_d = ~act_pol_q;
		end
	end

	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			field_q                 <= {FIELD_W{1'b0}};
			level_q                 <= `RST_START_POL;
			field_count_out         <= {FIELD_W{1'b0}};
			field_trigger_pulse_out <= `RST_START_POL;
			align_pin_out           <= `RST_START_POL;
			align_pin_oe_out        <= 1'b1;
			ext_sync_out            <= 1'b0;
		end else begin
			field_q                 <= field_d;
			level_q                 <= level_d;
			field_count_out         <= field_d;
			field_trigger_pulse_out <= level_d;
			align_pin_out           <= level_d;
			align_pin_oe_out        <= ~act_dir_q;
			ext_sync_out            <= act_dir_q & align_pin_in;
		end
	end

endmodule

// ===== field_trigger_consts.vh
/*
 * Constants for the field trigger pulse generator: register offsets, field
 * positions, reset values and serial frame widths.
 * Assumes inclusion by bare name from the pulse generator and serial port design files.
 */
// Functional notes
// - generate trigger pulse, drive onto align pin
// - waveform from second shutter polarity and toggles
// - ignore shutter field settings, use mode count
// - control bits 2:0 select target field count
// - control bit 3 enables pulse output
// - direction bit 0: 0 output, 1 sync input
// - default configuration drives pulse on pin
// - polarity bit 1 sets field start level
// - first toggle at on line and pixel
// - second toggle at off line and pixel
// - serial writes apply at next drive falling edge; here they apply at the first hd fall at or after a vd fall
// - vertical drive falling edge advances field count
`ifndef FIELD_TRIGGER_CONSTS_VH
`define FIELD_TRIGGER_CONSTS_VH

// serial frame: address then data, both lsb first
`define SER_ADDR_W        12
`define SER_DATA_W        28
`define SER_FRAME_W       40

// register offsets
`define ADDR_PIN_DIR      12'h0012
`define ADDR_START_POL    12'h0072
`define ADDR_ON_POS       12'h0074
`define ADDR_OFF_POS      12'h0076
`define ADDR_PULSE_CTRL   12'h00f1

// field positions
`define DIR_BIT           0
`define POL_BIT           1
`define CTRL_SEL_HI       2
`define CTRL_SEL_LO       0
`define CTRL_EN_BIT       3
`define POS_LINE_HI       11
`define POS_LINE_LO       0
`define POS_PIX_HI        25
`define POS_PIX_LO        13

// reset values
`define RST_PIN_DIR       1'b0
`define RST_START_POL     1'b0
`define RST_CTRL          4'h0
`define RST_LINE          12'h000
`define RST_PIX           13'h0000

`endif

// ===== serial_write_port.v
/*
 * Three-wire serial write port. Collects an address and data frame while
 * the load strobe is low and issues one write pulse when it rises after a 40-bit frame.
 * Assumes sclk, sdata and load are synchronous to mclk and much slower.
 */
`timescale 1ns/1ps
`include "field_trigger_consts.vh"

module serial_write_port (
	// clock and reset
	input  wire                   mclk_in,
	input  wire                   rst_n_in,
	// serial pins
	input  wire                   sclk_in,
	input  wire                   sdata_in,
	input  wire                   sload_n_in,
	// write strobe
	output reg                    wr_out,
	output reg  [`SER_ADDR_W-1:0] wr_addr_out,
	output reg  [`SER_DATA_W-1:0] wr_data_out
);

	reg  [`SER_FRAME_W-1:0] shift_q;
	reg  [5:0]              count_q;
	reg                     sclk_q;
	reg                     sload_n_q;
	wire                    sclk_rise;
	wire                    load_rise;

	assign sclk_rise = sclk_in & ~sclk_q & ~sload_n_in;
	assign load_rise = sload_n_in & ~sload_n_q;

	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			shift_q     <= {`SER_FRAME_W{1'b0}};
			count_q     <= 6'h00;
			sclk_q      <= 1'b0;
			sload_n_q   <= 1'b1;
			wr_out      <= 1'b0;
			wr_addr_out <= {`SER_ADDR_W{1'b0}};
			wr_data_out <= {`SER_DATA_W{1'b0}};
		end else begin
			sclk_q    <= sclk_in;
			sload_n_q <= sload_n_in;
			wr_out    <= 1'b0;
			if (sload_n_in) begin
				count_q <= 6'h00;
			end else if (sclk_rise) begin
				// lsb first: new bit enters at the top
				shift_q <= {sdata_in, shift_q[`SER_FRAME_W-1:1]};
				if (count_q != 6'h3f)
					count_q <= count_q + 6'h01;
			end
			// short or long frames are dropped
			if (load_rise && count_q == 6'h28) begin
				wr_out      <= 1'b1;
				wr_addr_out <= shift_q[`SER_ADDR_W-1:0];
				wr_data_out <= shift_q[`SER_FRAME_W-1:`SER_ADDR_W];
			end
		end
	end

endmodule

// ===== drive_position_counter.v
/*
 * Line and pixel position counter framed by the drive strobes.
 * Assumes strobe falling edges arrive as one-cycle pulses from the caller.
 */
`timescale 1ns/1ps

module drive_position_counter #(
	parameter LINE_W = 12,
	parameter PIX_W  = 13
) (
	// clock and reset
	input  wire              mclk_in,
	input  wire              rst_n_in,
	// strobe edges
	input  wire              vd_fall_in,
	input  wire              hd_fall_in,
	// position
	output reg  [LINE_W-1:0] line_out,
	output reg  [PIX_W-1:0]  pixel_out
);

	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			line_out  <= {LINE_W{1'b0}};
			pixel_out <= {PIX_W{1'b0}};
		end else begin
			if (hd_fall_in)
				pixel_out <= {PIX_W{1'b0}};
			else if (pixel_out != {PIX_W{1'b1}})
				pixel_out <= pixel_out + {{(PIX_W-1){1'b0}}, 1'b1};
			if (vd_fall_in)
				line_out <= {LINE_W{1'b0}};
			else if (hd_fall_in && line_out != {LINE_W{1'b1}})
				line_out <= line_out + {{(LINE_W-1){1'b0}}, 1'b1};
		end
	end

endmodule

// ===== field_trigger_monitor.sv
/*
 * Checker for the field trigger pulse generator top module.
 * Assumes it sees only the top module ports, bound in below.
 */
`timescale 1ns/1ps

module field_trigger_monitor #(
	parameter FIELD_W = 3
) (
	input wire               mclk_in,
	input wire               rst_n_in,
	input wire               vertical_drive_strobe_in,
	input wire               horizontal_drive_strobe_in,
	input wire [FIELD_W-1:0] mode_field_total_in,
	input wire               align_pin_in,
	input wire               align_pin_out,
	input wire               align_pin_oe_out,
	input wire               ext_sync_out,
	input wire               field_trigger_pulse_out,
	input wire [FIELD_W-1:0] field_count_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	a_reset_values: assert property ($rose(rst_n_in) |-> align_pin_oe_out
		&& !field_trigger_pulse_out && field_count_out == '0 && !ext_sync_out)
		else $error("outputs not at reset values");
	a_sync_quiet_out: assert property (
		align_pin_oe_out && $past(align_pin_oe_out) |-> !ext_sync_out)
		else $error("sync input active while pin drives");
	a_sync_follows_pin: assert property (
		!align_pin_oe_out && !$past(align_pin_oe_out) |-> ext_sync_out == $past(align_pin_in))
		else $error("sync input does not follow pin");
	a_pin_carries_pulse: assert property (
		align_pin_oe_out |-> align_pin_out == field_trigger_pulse_out)
		else $error("pin does not carry pulse");
	a_field_needs_strobe: assert property (!$stable(field_count_out) |->
		!$past(vertical_drive_strobe_in) || !$past(vertical_drive_strobe_in, 2))
		else $error("field count moved without vertical edge");
	a_field_count_bound: assert property (
		field_count_out == '0 || field_count_out < mode_field_total_in)
		else $error("field count beyond sequence");
	a_field_single_step: assert property (!$stable(field_count_out) |->
		field_count_out == '0 || field_count_out == $past(field_count_out) + 1'b1)
		else $error("field count skipped");
	a_direction_at_update: assert property (!$stable(align_pin_oe_out) |->
		!$past(horizontal_drive_strobe_in) || !$past(horizontal_drive_strobe_in, 2))
		else $error("pin direction changed outside update point");

	c_field_wrap: cover property ($past(field_count_out) != '0 && field_count_out == '0);
	c_pulse_rise: cover property ($rose(field_trigger_pulse_out));
	c_pin_input: cover property ($fell(align_pin_oe_out));
endmodule

bind field_trigger_pulse_gen field_trigger_monitor #(.FIELD_W(FIELD_W)) mon (
	.mclk_in                   (mclk_in),
	.rst_n_in                  (rst_n_in),
	.vertical_drive_strobe_in  (vertical_drive_strobe_in),
	.horizontal_drive_strobe_in(horizontal_drive_strobe_in),
	.mode_field_total_in       (mode_field_total_in),
	.align_pin_in              (align_pin_in),
	.align_pin_out             (align_pin_out),
	.align_pin_oe_out          (align_pin_oe_out),
	.ext_sync_out              (ext_sync_out),
	.field_trigger_pulse_out   (field_trigger_pulse_out),
	.field_count_out           (field_count_out)
);

// ===== align_pin_partner.sv
/*
 * Board side of the shared align pin: a sync source that drives the
 * pin only while the device has released it.
 * Assumes the bench changes the sync level just after a clock edge.
 */
`timescale 1ns/1ps

module align_pin_partner (
	// device pin drive
	input  wire pin_out_in,
	input  wire pin_oe_in,
	// board sync source
	input  wire sync_drive_in,
	// resolved wire level
	output wire pin_level_out
);
	assign pin_level_out = pin_oe_in ? pin_out_in : sync_drive_in;
endmodule

// ===== tb.sv
/*
 * Bench for the field trigger pulse generator: serial writes, framed
 * fields of three lines, pulse, field count and pin checks.
 * Assumes a three-field, then a four-field mode sequence.
 */
`timescale 1ns/1ps

`define CHK(nm, e, a) begin comparisons = comparisons + 1; if ((a) !== (e)) begin \
	miscompares = miscompares + 1; $display("CHECK FAILED %s exp %h got %h", nm, e, a); end end

module tb;
	reg        mclk_in     = 1'b0;
	reg        rst_n_in    = 1'b0;
	reg        sclk_in     = 1'b0;
	reg        sdata_in    = 1'b0;
	reg        sload_n_in  = 1'b1;
	reg        vert        = 1'b1;
	reg        horiz       = 1'b1;
	reg  [2:0] total       = 3'h3;
	reg        sync_drive  = 1'b0;
	wire       pin_level;
	wire       pin_out;
	wire       pin_oe;
	wire       ext_sync;
	wire       pulse;
	wire [2:0] field;
	integer    miscompares = 0;
	integer    comparisons = 0;
	integer    cycles      = 0;
	integer    s;
	reg  [2:0] exp_field   = 3'h0;
	reg  [2:0] sel         = 3'h0;
	reg        pol         = 1'b0;
	reg        en          = 1'b0;
	reg        dir         = 1'b0;

	field_trigger_pulse_gen uut (
		.mclk_in(mclk_in), .rst_n_in(rst_n_in), .sclk_in(sclk_in),
		.sdata_in(sdata_in), .sload_n_in(sload_n_in),
		.vertical_drive_strobe_in(vert), .horizontal_drive_strobe_in(horiz),
		.mode_field_total_in(total), .align_pin_in(pin_level),
		.align_pin_out(pin_out), .align_pin_oe_out(pin_oe), .ext_sync_out(ext_sync),
		.field_trigger_pulse_out(pulse), .field_count_out(field));

	align_pin_partner board (.pin_out_in(pin_out), .pin_oe_in(pin_oe),
		.sync_drive_in(sync_drive), .pin_level_out(pin_level));

	always #12.5 mclk_in = ~mclk_in;

	always @(posedge mclk_in) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			miscompares = miscompares + 1;
			tally_and_finish;
		end
	end

	task step(input integer n);
		begin
			repeat (n) @(posedge mclk_in);
			#2;
		end
	endtask

	task wr(input [11:0] a, input [27:0] d);
		reg [39:0] f;
		integer i;
		begin
			f = {d, a};
			sload_n_in = 1'b0;
			for (i = 0; i < 40; i = i + 1) begin
				sdata_in = f[i];
				sclk_in = 1'b0;
				step(1);
				sclk_in = 1'b1;
				step(1);
			end
			sclk_in = 1'b0;
			step(1);
			sload_n_in = 1'b1;
			step(4);
		end
	endtask

	task field_run(input chk);
		integer l;
		reg e;
		begin
			vert = 1'b0;
			step(2);
			vert = 1'b1;
			exp_field = ({1'b0, exp_field} + 4'h1 >= {1'b0, total}) ? 3'h0 : exp_field + 3'h1;
			step(2);
			for (l = 1; l < 4; l = l + 1) begin
				horiz = 1'b0;
				step(2);
				horiz = 1'b1;
				step(24);
				e = pol ^ (en && exp_field == sel && l == 1);
				if (chk) begin
					`CHK("pulse", e, pulse)
					`CHK("field", exp_field, field)
					if (!dir) `CHK("pin", e, pin_out)
				end
				step(14);
			end
		end
	endtask

	task tally_and_finish;
		begin
			$display("comparisons %0d miscompares %0d", comparisons, miscompares);
			if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
			else $display("Testbench failed");
			$finish;
		end
	endtask

	initial begin
		step(12);
		rst_n_in = 1'b1;
		step(2);
		`CHK("oe", 1'b1, pin_oe)
		`CHK("pulse", 1'b0, pulse)
		`CHK("sync", 1'b0, ext_sync)
		en = 1'b1;
		sel = 3'h1;
		wr(12'h0074, {2'h0, 13'h000a, 1'b0, 12'h001});
		wr(12'h0076, {2'h0, 13'h000a, 1'b0, 12'h002});
		wr(12'h00f1, 28'h000_0009);
		wr(12'h00f0, 28'h000_0000);
		field_run(1'b0);
		repeat (4) field_run(1'b1);
		pol = 1'b1;
		wr(12'h0072, 28'h000_0002);
		for (s = 0; s < 3; s = s + 1) begin
			sel = s[2:0];
			wr(12'h00f1, {24'h00_0000, 1'b1, sel});
			field_run(1'b0);
			repeat (3) field_run(1'b1);
		end
		en = 1'b0;
		wr(12'h00f1, 28'h000_0002);
		field_run(1'b0);
		repeat (3) field_run(1'b1);
		total = 3'h4;
		en = 1'b1;
		sel = 3'h3;
		wr(12'h00f1, 28'h000_000b);
		field_run(1'b0);
		repeat (4) field_run(1'b1);
		dir = 1'b1;
		wr(12'h0012, 28'h000_0001);
		field_run(1'b1);
		`CHK("oe", 1'b0, pin_oe)
		sync_drive = 1'b1;
		step(3);
		`CHK("sync", 1'b1, ext_sync)
		sync_drive = 1'b0;
		step(3);
		`CHK("sync", 1'b0, ext_sync)
		rst_n_in = 1'b0;
		step(2);
		rst_n_in = 1'b1;
		exp_field = 3'h0;
		step(2);
		`CHK("oe", 1'b1, pin_oe)
		`CHK("pulse", 1'b0, pulse)
		`CHK("field", exp_field, field)
		tally_and_finish;
	end
endmodule
